// [smbus_target.sv]
// smbus target end: protocol engine, pointer, register file, timeout, pec and alert response
`timescale 1ns/1ps
module smbus_target #(
	parameter int TIMEOUT_CYCLES = smbus_pkg::TIMEOUT_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	smbus_if.target bus,
	input wire logic [6:0] own_addr,
	input wire logic [smbus_pkg::TEMP_WIDTH-1:0] local_temp,
	input wire logic [smbus_pkg::TEMP_WIDTH-1:0] remote_temp,
	input wire logic fault,
	input wire logic monitor_tick,
	output logic [smbus_pkg::TEMP_WIDTH-1:0] fan_local_temp,
	output logic [smbus_pkg::TEMP_WIDTH-1:0] fan_remote_temp
);
	import smbus_pkg::*;

	localparam int TO_WIDTH = $clog2(TIMEOUT_CYCLES + 1);
	localparam int MEM_DEPTH = 2 ** ADDR_WIDTH;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RX = 3'b010,
		ST_TX = 3'b100
	} state_t;

	logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
	state_t state, next_state;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shift, next_shift;
	logic [5:0] byte_idx, next_byte_idx;
	logic in_frame, next_in_frame;
	logic is_read, next_is_read;
	logic ara, next_ara;
	logic sda_low, next_sda_low;
	logic [7:0] pointer, next_pointer;
	logic [5:0] block_count, next_block_count;
	logic [5:0] pend_count, next_pend_count;
	logic pec_seen, next_pec_seen;
	logic pec_bad, next_pec_bad;
	logic [7:0] crc, next_crc;
	logic [5:0] tx_idx, next_tx_idx;
	logic host_ack, next_host_ack;
	logic lock, next_lock;
	logic alert_active, next_alert_active;
	logic [TEMP_WIDTH-1:0] frz_local, next_frz_local, frz_remote, next_frz_remote;
	logic [TO_WIDTH-1:0] to_cnt, next_to_cnt;
	logic [7:0] stage [MAX_BLOCK];
	logic [7:0] next_stage [MAX_BLOCK];
	logic [7:0] mem [MEM_DEPTH];
	logic [7:0] next_mem [MEM_DEPTH];

	logic scl_rise, scl_fall, start_cond, stop_cond, timeout, stuck, any_edge;
	logic ara_done, load_tx, commit, hdr, tx_is_reg;
	logic [7:0] cfg, tx_byte, reg_data;
	logic [5:0] rd_count, n_rd, data_len;
	logic [6:0] rd_addr;
	logic [2:0] bit_sel;

	assign scl_rise = scl_s2 && !scl_d;
	assign scl_fall = !scl_s2 && scl_d;
	assign start_cond = scl_s2 && scl_d && sda_d && !sda_s2;
	assign stop_cond = scl_s2 && scl_d && !sda_d && sda_s2;
	assign any_edge = (scl_s2 != scl_d) || (sda_s2 != sda_d);
	assign cfg = mem[REG_CONFIGURATION_ONE];
	// inactivity only counts against a line held low while a frame is open
	assign stuck = (cfg[CFG_SCL_TIMEOUT_BIT] && !scl_s2) ||
		(cfg[CFG_SDA_TIMEOUT_BIT] && !sda_s2);
	assign timeout = to_cnt == TO_WIDTH'(TIMEOUT_CYCLES - 1);
	assign bit_sel = 3'(4'h7 - bit_cnt);
	assign rd_count = (mem[REG_BLOCK_READ_COUNT] > 8'(MAX_BLOCK)) ? MAX_BLOCK :
		mem[REG_BLOCK_READ_COUNT][5:0];
	assign data_len = pointer[PTR_BLOCK_BIT] ? block_count : 6'h01;
	assign hdr = pointer[PTR_BLOCK_BIT] && !ara;
	assign n_rd = hdr ? rd_count : 6'h01;
	assign rd_addr = 7'(pointer[6:0] + 7'(tx_idx - 6'(hdr)));

	assign bus.dev_sda_out = 1'b0;
	assign bus.dev_sda_oe_n = !sda_low;
	assign bus.dev_alert_out = 1'b0;
	assign bus.dev_alert_oe_n = !alert_active;

	// temperature view; low byte carries the five fraction bits left aligned
	always_comb begin
		unique case (rd_addr)
			REG_LOCAL_LSB: reg_data = {frz_local[TEMP_FRAC-1:0], 3'h0};
			REG_LOCAL_MSB: reg_data = frz_local[TEMP_WIDTH-1:TEMP_FRAC];
			REG_REMOTE_LSB: reg_data = {frz_remote[TEMP_FRAC-1:0], 3'h0};
			REG_REMOTE_MSB: reg_data = frz_remote[TEMP_WIDTH-1:TEMP_FRAC];
			default: reg_data = mem[rd_addr];
		endcase
	end

	always_comb begin
		tx_is_reg = 1'b0;
		if (hdr && tx_idx == 6'h00) begin
			tx_byte = {2'h0, rd_count};
		end else if (tx_idx < n_rd + 6'(hdr)) begin
			tx_byte = ara ? {own_addr, 1'b0} : reg_data;
			tx_is_reg = !ara;
		end else if (tx_idx == n_rd + 6'(hdr)) begin
			tx_byte = crc;
		end else begin
			tx_byte = 8'hff;
		end
	end

	always_comb begin
		logic ack;
		ack = 1'b1;
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_byte_idx = byte_idx;
		next_in_frame = in_frame;
		next_is_read = is_read;
		next_ara = ara;
		next_sda_low = sda_low;
		next_pointer = pointer;
		next_block_count = block_count;
		next_pend_count = pend_count;
		next_pec_seen = pec_seen;
		next_pec_bad = pec_bad;
		next_crc = crc;
		next_tx_idx = tx_idx;
		next_host_ack = host_ack;
		next_lock = lock;
		next_stage = stage;
		next_mem = mem;
		ara_done = 1'b0;
		load_tx = 1'b0;
		commit = 1'b0;
		next_to_cnt = (in_frame && stuck && !any_edge) ? TO_WIDTH'(to_cnt + 1'b1) : '0;
		if (start_cond) begin
			// a repeated start keeps pointer, staged write and crc of the frame
			next_state = ST_RX;
			next_bit_cnt = 4'h0;
			next_byte_idx = 6'h00;
			next_sda_low = 1'b0;
			next_tx_idx = 6'h00;
			next_in_frame = 1'b1;
			if (!in_frame) begin
				next_crc = 8'h00;
				next_pend_count = 6'h00;
				next_pec_seen = 1'b0;
				next_pec_bad = 1'b0;
			end
		end else if (stop_cond) begin
			next_state = ST_IDLE;
			next_sda_low = 1'b0;
			next_in_frame = 1'b0;
			commit = pend_count != 6'h00 && !pec_bad;
			next_pend_count = 6'h00;
		end else if (timeout) begin
			next_state = ST_IDLE;
			next_sda_low = 1'b0;
			next_in_frame = 1'b0;
			next_pend_count = 6'h00;
		end else if (state == ST_RX) begin
			if (scl_rise && bit_cnt < BIT_ACK_SLOT) begin
				next_shift = {shift[6:0], sda_s2};
				next_bit_cnt = bit_cnt + 4'h1;
			end else if (scl_fall && bit_cnt == BIT_ACK_SLOT) begin
				next_crc = crc8_update(crc, shift);
				if (byte_idx != 6'h3f) begin
					next_byte_idx = byte_idx + 6'h01;
				end
				if (byte_idx == 6'h00) begin
					next_ara = 1'b0;
					if (shift[7:1] == own_addr) begin
						next_is_read = shift[0];
					end else if (shift[7:1] == ALERT_RESPONSE_ADDR && shift[0] && alert_active) begin
						next_is_read = 1'b1;
						next_ara = 1'b1;
					end else begin
						ack = 1'b0;
						next_state = ST_IDLE;
					end
				end else if (byte_idx == 6'h01) begin
					next_pointer = shift;
				end else if (pointer[PTR_BLOCK_BIT] && byte_idx == 6'h02) begin
					// oversize counts are cut to the block limit
					next_block_count = (shift > 8'(MAX_BLOCK)) ? MAX_BLOCK : shift[5:0];
				end else if (pend_count < data_len) begin
					next_stage[pend_count[4:0]] = shift;
					next_pend_count = pend_count + 6'h01;
				end else if (!pec_seen) begin
					next_pec_seen = 1'b1;
					next_pec_bad = shift != crc;
					ack = shift == crc;
				end else begin
					ack = 1'b0;
				end
				next_sda_low = ack;
				next_bit_cnt = BIT_ACK_DONE;
			end else if (scl_fall && bit_cnt == BIT_ACK_DONE) begin
				next_sda_low = 1'b0;
				next_bit_cnt = 4'h0;
				load_tx = is_read;
			end
		end else if (state == ST_TX) begin
			if (scl_rise && bit_cnt < BIT_ACK_SLOT) begin
				if (!sda_low && !sda_s2) begin
					next_state = ST_IDLE;
				end else begin
					next_bit_cnt = bit_cnt + 4'h1;
				end
			end else if (scl_fall && bit_cnt != 4'h0 && bit_cnt < BIT_ACK_SLOT) begin
				next_sda_low = !shift[bit_sel];
			end else if (scl_fall && bit_cnt == BIT_ACK_SLOT) begin
				next_sda_low = 1'b0;
				next_crc = crc8_update(crc, shift);
				next_tx_idx = tx_idx + 6'h01;
				ara_done = ara;
			end else if (scl_rise && bit_cnt == BIT_ACK_SLOT) begin
				next_host_ack = !sda_s2;
				next_bit_cnt = BIT_ACK_DONE;
			end else if (scl_fall && bit_cnt == BIT_ACK_DONE) begin
				load_tx = host_ack;
				if (!host_ack) begin
					next_state = ST_IDLE;
				end
			end
		end
		if (load_tx) begin
			next_state = ST_TX;
			next_shift = tx_byte;
			next_sda_low = !tx_byte[7];
			next_bit_cnt = 4'h0;
			if (tx_is_reg && (rd_addr == REG_LOCAL_LSB || rd_addr == REG_REMOTE_LSB)) begin
				next_lock = 1'b1;
			end else if (tx_is_reg && (rd_addr == REG_LOCAL_MSB || rd_addr == REG_REMOTE_MSB)) begin
				next_lock = 1'b0;
			end
		end
		for (int i = 0; i < MAX_BLOCK; i++) begin
			if (commit && 6'(i) < pend_count) begin
				next_mem[7'(pointer[6:0] + 7'(i))] = stage[i];
			end
		end
	end

	// a raised alert wins over the clear of the same cycle
	assign next_alert_active = (alert_active && !ara_done) || (fault && monitor_tick);
	assign next_frz_local = lock ? frz_local : local_temp;
	assign next_frz_remote = lock ? frz_remote : remote_temp;

	always_ff @(posedge clock) begin
		scl_s1 <= bus.scl;
		scl_s2 <= scl_s1;
		sda_s1 <= bus.sda;
		sda_s2 <= sda_s1;
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			byte_idx <= 6'h00;
			in_frame <= 1'b0;
			is_read <= 1'b0;
			ara <= 1'b0;
			sda_low <= 1'b0;
			pointer <= 8'h00;
			block_count <= 6'h00;
			pend_count <= 6'h00;
			pec_seen <= 1'b0;
			pec_bad <= 1'b0;
			crc <= 8'h00;
			tx_idx <= 6'h00;
			host_ack <= 1'b0;
			lock <= 1'b0;
			alert_active <= 1'b0;
			frz_local <= '0;
			frz_remote <= '0;
			to_cnt <= '0;
			fan_local_temp <= '0;
			fan_remote_temp <= '0;
			for (int i = 0; i < MAX_BLOCK; i++) begin
				stage[i] <= 8'h00;
			end
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem[i] <= REG_RESET;
			end
		end else begin
			scl_d <= scl_s2;
			sda_d <= sda_s2;
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			byte_idx <= next_byte_idx;
			in_frame <= next_in_frame;
			is_read <= next_is_read;
			ara <= next_ara;
			sda_low <= next_sda_low;
			pointer <= next_pointer;
			block_count <= next_block_count;
			pend_count <= next_pend_count;
			pec_seen <= next_pec_seen;
			pec_bad <= next_pec_bad;
			crc <= next_crc;
			tx_idx <= next_tx_idx;
			host_ack <= next_host_ack;
			lock <= next_lock;
			alert_active <= next_alert_active;
			frz_local <= next_frz_local;
			frz_remote <= next_frz_remote;
			to_cnt <= next_to_cnt;
			fan_local_temp <= local_temp;
			fan_remote_temp <= remote_temp;
			stage <= next_stage;
			mem <= next_mem;
		end
	end
endmodule

// [smbus_pkg.sv]
// shared constants, register map and crc helper for the smbus target and controller
package smbus_pkg;
	localparam int CLOCK_HZ = 25_000_000;
	localparam int TIMEOUT_MS = 25;
	localparam int TIMEOUT_CYCLES = CLOCK_HZ / 1000 * TIMEOUT_MS;
	localparam int ADDR_WIDTH = 7;
	localparam int TEMP_WIDTH = 13;
	localparam int TEMP_FRAC = 5;
	localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0c;
	localparam logic [6:0] REG_BLOCK_READ_COUNT = 7'h00;
	localparam logic [6:0] REG_CONFIGURATION_ONE = 7'h01;
	localparam logic [6:0] REG_LOCAL_LSB = 7'h40;
	localparam logic [6:0] REG_LOCAL_MSB = 7'h41;
	localparam logic [6:0] REG_REMOTE_LSB = 7'h42;
	localparam logic [6:0] REG_REMOTE_MSB = 7'h43;
	localparam int CFG_SDA_TIMEOUT_BIT = 5;
	localparam int CFG_SCL_TIMEOUT_BIT = 4;
	localparam int PTR_BLOCK_BIT = 7;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [5:0] MAX_BLOCK = 6'h20;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
	localparam logic [3:0] BIT_ACK_DONE = 4'h9;
	localparam logic [7:0] HREG_COMMAND = 8'h00;
	localparam logic [7:0] HREG_STATUS = 8'h04;
	localparam logic [7:0] HREG_DIVIDER = 8'h08;
	localparam logic [2:0] CMD_START = 3'h1;
	localparam logic [2:0] CMD_STOP = 3'h2;
	localparam logic [2:0] CMD_WRITE = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h4;
	localparam int CMD_DATA_LSB = 8;
	localparam int CMD_NACK_BIT = 16;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_ACK_BIT = 1;
	localparam int ST_ALERT_BIT = 2;
	localparam int ST_RX_LSB = 8;
	localparam int ST_CRC_LSB = 16;
	localparam logic [15:0] DIVIDER_RESET = 16'h003f;
	localparam logic [1:0] PHASE_LAST = 2'h3;

	function automatic logic [7:0] crc8_update(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction
endpackage

// [smbus_if.sv]
// open-drain smbus wires shared by the controller and the target
`timescale 1ns/1ps
interface smbus_if;
	logic host_scl_out;
	logic host_scl_oe_n;
	logic host_sda_out;
	logic host_sda_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;
	logic dev_alert_out;
	logic dev_alert_oe_n;
	logic scl;
	logic sda;
	logic alert_n;

	// wired-and: a line is low only while some party enables a low drive
	assign scl = host_scl_oe_n || host_scl_out;
	assign sda = (host_sda_oe_n || host_sda_out) && (dev_sda_oe_n || dev_sda_out);
	assign alert_n = dev_alert_oe_n || dev_alert_out;

	modport target(
		input scl,
		input sda,
		output dev_sda_out,
		output dev_sda_oe_n,
		output dev_alert_out,
		output dev_alert_oe_n
	);
	modport controller(
		input scl,
		input sda,
		input alert_n,
		output host_scl_out,
		output host_scl_oe_n,
		output host_sda_out,
		output host_sda_oe_n
	);
endinterface

// [smbus_host.sv]
// smbus controller end: apb command registers driving start, stop and byte cycles
`timescale 1ns/1ps
module smbus_host (
	input wire logic clock,
	input wire logic rst,
	smbus_if.controller bus,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import smbus_pkg::*;

	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_START = 4'b0010,
		H_STOP = 4'b0100,
		H_BYTE = 4'b1000
	} hstate_t;

	hstate_t state, next_state;
	logic scl_s1, scl_s2, sda_s1, sda_s2, alert_s1, alert_s2;
	logic [15:0] divider, next_divider, div_cnt, next_div_cnt;
	logic [1:0] phase, next_phase;
	logic [3:0] bit_idx, next_bit_idx;
	logic is_read, next_is_read, nack, next_nack;
	logic [7:0] tx_data, next_tx_data, rx_data, next_rx_data, crc, next_crc;
	logic target_ack, next_target_ack, frame, next_frame;
	logic scl_low, next_scl_low, sda_low, next_sda_low;
	logic [31:0] next_prdata;
	logic next_pslverr, tick, wr_cmd, setup, access;

	assign pready = 1'b1;
	assign setup = psel && !penable;
	// writes land on the access edge, where the master samples pready
	assign access = psel && penable && pready;
	assign wr_cmd = access && pwrite && paddr == HREG_COMMAND && state == H_IDLE;
	assign tick = div_cnt == 16'h0000;
	assign bus.host_scl_out = 1'b0;
	assign bus.host_scl_oe_n = !scl_low;
	assign bus.host_sda_out = 1'b0;
	assign bus.host_sda_oe_n = !sda_low;

	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (setup) begin
			unique case (paddr)
				HREG_COMMAND: next_pslverr = pwrite && state != H_IDLE;
				HREG_DIVIDER: next_prdata = {16'h0000, divider};
				HREG_STATUS: begin
					next_prdata[ST_BUSY_BIT] = state != H_IDLE;
					next_prdata[ST_ACK_BIT] = target_ack;
					next_prdata[ST_ALERT_BIT] = !alert_s2;
					next_prdata[ST_RX_LSB +: 8] = rx_data;
					next_prdata[ST_CRC_LSB +: 8] = crc;
				end
				default: next_pslverr = 1'b1;
			endcase
		end else begin
			next_prdata = prdata;
			next_pslverr = pslverr;
		end
	end

	always_comb begin
		next_state = state;
		next_divider = divider;
		next_div_cnt = tick ? divider : div_cnt - 16'h0001;
		next_phase = phase;
		next_bit_idx = bit_idx;
		next_is_read = is_read;
		next_nack = nack;
		next_tx_data = tx_data;
		next_rx_data = rx_data;
		next_crc = crc;
		next_target_ack = target_ack;
		next_frame = frame;
		next_scl_low = scl_low;
		next_sda_low = sda_low;
		if (access && pwrite && paddr == HREG_DIVIDER) begin
			next_divider = pwdata[15:0];
		end
		if (wr_cmd) begin
			next_phase = 2'h0;
			next_bit_idx = 4'h0;
			next_tx_data = pwdata[CMD_DATA_LSB +: 8];
			next_nack = pwdata[CMD_NACK_BIT];
			next_div_cnt = divider;
			unique case (pwdata[2:0])
				CMD_START: next_state = H_START;
				CMD_STOP: next_state = H_STOP;
				CMD_WRITE: begin
					next_state = H_BYTE;
					next_is_read = 1'b0;
				end
				CMD_READ: begin
					next_state = H_BYTE;
					next_is_read = 1'b1;
				end
				default: next_state = H_IDLE;
			endcase
		end else if (tick && state != H_IDLE && !(phase == 2'h2 && !scl_s2)) begin
			// phase 2 waits until the released clock is seen high (stretching)
			next_phase = phase + 2'h1;
			unique case (state)
				H_START: begin
					unique case (phase)
						2'h0: next_sda_low = 1'b0;
						2'h1: next_scl_low = 1'b0;
						2'h2: next_sda_low = 1'b1;
						default: begin
							next_scl_low = 1'b1;
							next_state = H_IDLE;
							if (!frame) begin
								next_crc = 8'h00;
							end
							next_frame = 1'b1;
						end
					endcase
				end
				H_STOP: begin
					unique case (phase)
						2'h0: next_sda_low = 1'b1;
						2'h1: next_scl_low = 1'b0;
						2'h2: next_sda_low = 1'b0;
						default: begin
							next_state = H_IDLE;
							next_frame = 1'b0;
						end
					endcase
				end
				default: begin
					unique case (phase)
						2'h0: begin
							if (bit_idx == BIT_ACK_SLOT) begin
								next_sda_low = is_read && !nack;
							end else begin
								next_sda_low = !is_read && !tx_data[3'(4'h7 - bit_idx)];
							end
						end
						2'h1: next_scl_low = 1'b0;
						2'h2: begin
							if (bit_idx == BIT_ACK_SLOT) begin
								next_target_ack = !sda_s2;
							end else begin
								next_rx_data = {rx_data[6:0], sda_s2};
							end
						end
						default: begin
							next_scl_low = 1'b1;
							next_bit_idx = bit_idx + 4'h1;
							if (bit_idx == BIT_ACK_SLOT) begin
								next_sda_low = 1'b0;
								next_state = H_IDLE;
								next_crc = crc8_update(crc, is_read ? rx_data : tx_data);
							end
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		scl_s1 <= bus.scl;
		scl_s2 <= scl_s1;
		sda_s1 <= bus.sda;
		sda_s2 <= sda_s1;
		alert_s1 <= bus.alert_n;
		alert_s2 <= alert_s1;
		if (rst) begin
			state <= H_IDLE;
			divider <= DIVIDER_RESET;
			div_cnt <= DIVIDER_RESET;
			phase <= 2'h0;
			bit_idx <= 4'h0;
			is_read <= 1'b0;
			nack <= 1'b0;
			tx_data <= 8'h00;
			rx_data <= 8'h00;
			crc <= 8'h00;
			target_ack <= 1'b0;
			frame <= 1'b0;
			scl_low <= 1'b0;
			sda_low <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			state <= next_state;
			divider <= next_divider;
			div_cnt <= next_div_cnt;
			phase <= next_phase;
			bit_idx <= next_bit_idx;
			is_read <= next_is_read;
			nack <= next_nack;
			tx_data <= next_tx_data;
			rx_data <= next_rx_data;
			crc <= next_crc;
			target_ack <= next_target_ack;
			frame <= next_frame;
			scl_low <= next_scl_low;
			sda_low <= next_sda_low;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end
endmodule

// [smbus_monitor.sv]
// concurrent checks on the smbus wires between controller and target
`timescale 1ns/1ps
module smbus_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_scl_oe_n,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n,
	input wire logic dev_alert_oe_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	AST_RESET_RELEASE: assert property (@(posedge clock) disable iff (1'b0)
		rst |=> dev_sda_oe_n && dev_alert_oe_n && host_scl_oe_n && host_sda_oe_n)
		else $error("wires not released in reset");
	AST_TGT_SDA_SCL_LOW: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("target moved sda while scl high");
	AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl[*4])
		else $error("scl high phase too short");
	AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl[*4])
		else $error("scl low phase too short");
	AST_START_BY_HOST: assert property ($fell(sda) && scl && $past(scl) |-> !host_sda_oe_n)
		else $error("start not made by controller");
	AST_IDLE_AFTER_STOP: assert property ($rose(sda) && scl && $past(scl) |-> dev_sda_oe_n[*4])
		else $error("target drives after stop");
	AST_TGT_DRIVE_HOLD: assert property ($fell(dev_sda_oe_n) |-> !scl[*3])
		else $error("target drive began late in low phase");
	AST_ALERT_CLEAR_AT_ADDR_END: assert property ($rose(dev_alert_oe_n) |-> !scl && $rose(dev_sda_oe_n))
		else $error("alert released outside end of returned address byte");
endmodule

// [testbench.sv]
// apb-driven controller talking to the smbus target, self-checking
`timescale 1ns/1ps
module testbench;
	import smbus_pkg::*;
	localparam int TO = 200;
	localparam logic [6:0] ADR = 7'h2c;
	logic clock = 0;
	logic rst = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [12:0] ltemp = 13'h0a5b;
	logic [12:0] rtemp = 13'h0123;
	logic fault = 0;
	logic tick = 0;
	logic [12:0] fan_l;
	logic [12:0] fan_r;
	logic [31:0] rd;
	logic err;
	logic [7:0] cr = 8'h00;
	logic [7:0] cfgs [3] = '{8'h00, 8'h20, 8'h10};
	int fail_count = 0;
	int compares = 0;
	smbus_if link();
	smbus_target #(.TIMEOUT_CYCLES(TO)) smbus_target_inst (.clock(clock), .rst(rst),
		.bus(link), .own_addr(ADR), .local_temp(ltemp), .remote_temp(rtemp),
		.fault(fault), .monitor_tick(tick), .fan_local_temp(fan_l), .fan_remote_temp(fan_r));
	smbus_host smbus_host_inst (.clock(clock), .rst(rst), .bus(link), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	smbus_monitor smbus_monitor_inst (.clock(clock), .rst(rst), .scl(link.scl),
		.sda(link.sda), .host_scl_oe_n(link.host_scl_oe_n),
		.host_sda_oe_n(link.host_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n),
		.dev_alert_oe_n(link.dev_alert_oe_n));
	initial begin
		forever #20 clock = ~clock;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// own bitwise crc so expectations do not lean on the design's helper
	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] x;
		x = c ^ b;
		for (int i = 0; i < 8; i++)
			x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
		return x;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input logic [2:0] c, input logic [7:0] d, input logic n);
		apb(1'b1, HREG_COMMAND, {15'h0, n, d, 5'h0, c});
		rd = 32'h1;
		while (rd[ST_BUSY_BIT] === 1'b1)
			apb(1'b0, HREG_STATUS, 32'h0);
	endtask
	task automatic st;
		cmd(CMD_START, 8'h00, 1'b0);
	endtask
	task automatic sp;
		cmd(CMD_STOP, 8'h00, 1'b0);
		cr = 8'h00;
	endtask
	task automatic wb(input logic [7:0] b, input logic a);
		cmd(CMD_WRITE, b, 1'b0);
		cr = crc(cr, b);
		chk("ack", {15'h0, a}, {15'h0, rd[ST_ACK_BIT]});
	endtask
	task automatic rb(input logic [7:0] e, input logic n);
		cmd(CMD_READ, 8'h00, n);
		chk("rx", {8'h0, e}, {8'h0, rd[15:8]});
		cr = crc(cr, e);
	endtask
	task automatic head(input logic [7:0] p);
		st;
		wb({ADR, 1'b0}, 1'b1);
		wb(p, 1'b1);
		st;
		wb({ADR, 1'b1}, 1'b1);
	endtask
	task automatic rreg(input logic [7:0] p, input logic [7:0] e);
		head(p);
		rb(e, 1'b1);
		sp;
	endtask
	task automatic wreg(input logic [7:0] p, input logic [7:0] v);
		st;
		wb({ADR, 1'b0}, 1'b1);
		wb(p, 1'b1);
		wb(v, 1'b1);
		sp;
	endtask
	task automatic alarm;
		@(posedge clock);
		tick <= 1'b1;
		@(posedge clock);
		tick <= 1'b0;
		repeat (4) @(posedge clock);
		apb(1'b0, HREG_STATUS, 32'h0);
	endtask
	initial begin
		repeat (90000) @(posedge clock);
		fail_count++;
		give_verdict;
	end
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		repeat (5) @(posedge clock);
		apb(1'b0, HREG_DIVIDER, 32'h0);
		chk("divider", DIVIDER_RESET, rd[15:0]);
		apb(1'b0, 8'h0c, 32'h0);
		chk("unmapped", 16'h1, {15'h0, err});
		// quarter of 12 clocks keeps the run short but above the target's lag
		apb(1'b1, HREG_DIVIDER, 32'h0b);
		wreg(8'h05, 8'ha5);
		head(8'h05);
		rb(8'ha5, 1'b0);
		rb(cr, 1'b1);
		sp;
		st;
		wb({ADR, 1'b1}, 1'b1);
		rb(8'ha5, 1'b1);
		sp;
		st;
		wb({ADR, 1'b0}, 1'b1);
		wb(8'h05, 1'b1);
		wb(8'h5a, 1'b1);
		wb(~cr, 1'b0);
		sp;
		rreg(8'h05, 8'ha5);
		st;
		wb({ADR, 1'b0}, 1'b1);
		wb(8'h86, 1'b1);
		wb(8'h03, 1'b1);
		for (int i = 1; i < 4; i++)
			wb(8'(8'h11 * i), 1'b1);
		sp;
		wreg(8'h00, 8'h03);
		head(8'h86);
		rb(8'h03, 1'b0);
		for (int i = 1; i < 4; i++)
			rb(8'(8'h11 * i), i == 3);
		sp;
		wreg(8'h00, 8'h28);
		head(8'h86);
		rb({2'b00, MAX_BLOCK}, 1'b1);
		sp;
		rreg(8'h40, 8'hd8);
		ltemp <= 13'h1c37;
		rtemp <= 13'h0456;
		repeat (3) @(posedge clock);
		chk("fan", 16'h1c37, {3'h0, fan_l});
		chk("fan_remote", 16'h0456, {3'h0, fan_r});
		rreg(8'h42, 8'h18);
		rreg(8'h41, 8'h52);
		st;
		wb({ADR, 1'b1}, 1'b1);
		rb(8'he1, 1'b1);
		sp;
		st;
		wb({ALERT_RESPONSE_ADDR, 1'b1}, 1'b0);
		sp;
		fault <= 1'b1;
		alarm;
		chk("alert", 16'h1, {15'h0, rd[ST_ALERT_BIT]});
		st;
		wb({ALERT_RESPONSE_ADDR, 1'b1}, 1'b1);
		rb({ADR, 1'b0}, 1'b1);
		sp;
		apb(1'b0, HREG_STATUS, 32'h0);
		chk("alert", 16'h0, {15'h0, rd[ST_ALERT_BIT]});
		alarm;
		chk("alert", 16'h1, {15'h0, rd[ST_ALERT_BIT]});
		for (int k = 0; k < 3; k++) begin
			wreg(8'h01, cfgs[k]);
			head(8'h06);
			// target drives its first bit a few clocks after the clock falls
			repeat (4) @(posedge clock);
			chk("hold", 16'h0, {15'h0, link.dev_sda_oe_n});
			repeat (TO + 20) @(posedge clock);
			chk("release", {15'h0, cfgs[k] != 0}, {15'h0, link.dev_sda_oe_n});
			rb(cfgs[k] != 0 ? 8'hff : 8'h11, 1'b1);
			sp;
		end
		give_verdict;
	end
endmodule
